// File: gate_driver_fault_latch.sv
// controller that commands an isolated gate driver and recovers its fault latch
`timescale 1ns/1ps
`include "gdrv_defs.svh"
// Summary of operation
// - noninverting use: inverting input held low, noninverting toggled
// - inverting use: noninverting input high unless the fault line is low, inverting toggled
// - poll fault line, pull latch-clear low separately to recover driver
// - inverting use may feed the fault line back to noninverting input
// - shared wired-OR fault line low disables the one driver command
// - auto-reset: latch-clear follows the command, low phase clears latch
// - manual recovery: command inputs set to gate-off before latch-clear is pulled low
module gate_driver_fault_latch
  import gdrv_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_pwm,
  input wire logic i_invert_mode,
  input wire logic i_auto_reset,
  input wire logic i_fault_ack,
  input wire logic i_fault_n,
  output logic o_cmd_noninverting_in,
  output logic o_cmd_inverting_in,
  output logic o_latch_clear_n,
  output logic o_fault_seen,
  output logic o_fault_state,
  output logic o_fault_pulse_short
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  logic fault_sync;
  logic fault_now;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // fault line from the device pin, inverted to active high before sync
  sync2 u_fault_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_d(~i_fault_n),
    .o_q(fault_sync)
  );
  assign fault_now = fault_sync;

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic [`CLR_PULSE_CYC_W-1:0] cnt_reg;
  logic [`CLR_PULSE_CYC_W-1:0] cnt_next;
  logic [`CLR_PULSE_CYC_W-1:0] low_cnt_reg;
  logic [`CLR_PULSE_CYC_W-1:0] low_cnt_next;
  logic gate_on_reg;
  logic gate_on_next;
  logic clr_n_reg;
  logic clr_n_next;
  logic seen_reg;
  logic seen_next;
  logic short_reg;
  logic short_next;
  logic nin_reg;
  logic nin_next;
  logic inv_reg;
  logic inv_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    gate_on_next = gate_on_reg;
    clr_n_next = 1'b1;
    seen_next = seen_reg;
    case (state_reg)
      ST_RUN: begin
        gate_on_next = i_pwm;
        if (fault_now) begin
          gate_on_next = 1'b0;
          seen_next = 1'b1;
          state_next = i_auto_reset ? ST_RUN : ST_FAULT;
        end
        if (i_auto_reset) begin
          clr_n_next = gate_on_next;
        end
      end
      ST_FAULT: begin
        gate_on_next = 1'b0;
        if (i_fault_ack) begin
          cnt_next = `CNT_ZERO;
          state_next = ST_SAFE;
        end
      end
      ST_SAFE: begin
        gate_on_next = 1'b0;
        cnt_next = `CLR_PULSE_CYC;
        state_next = ST_CLEAR;
      end
      ST_CLEAR: begin
        gate_on_next = 1'b0;
        clr_n_next = 1'b0;
        cnt_next = cnt_reg - `CNT_ONE;
        if (cnt_reg == `CNT_ZERO) begin
          clr_n_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
        gate_on_next = 1'b0;
      end
    endcase
    if (i_fault_ack && state_reg != ST_FAULT) begin
      seen_next = 1'b0;
    end
    if (fault_now) begin
      seen_next = 1'b1;
    end
  end

  // measures device fault pulse width in auto-reset mode
  always_comb begin
    low_cnt_next = low_cnt_reg;
    short_next = short_reg;
    // ack clears first so a short pulse in the same cycle still sets
    if (i_fault_ack) begin
      short_next = 1'b0;
    end
    if (fault_now) begin
      if (low_cnt_reg != `CLR_PULSE_CYC) begin
        low_cnt_next = low_cnt_reg + `CNT_ONE;
      end
    end else begin
      low_cnt_next = `CNT_ZERO;
      if (i_auto_reset && low_cnt_reg != `CNT_ZERO &&
          low_cnt_reg < `CLR_PULSE_CYC) begin
        short_next = 1'b1;
      end
    end
  end

  // pin encoding of the gate command
  always_comb begin
    if (i_invert_mode) begin
      nin_next = ~fault_now;
      inv_next = ~gate_on_next;
    end else begin
      nin_next = gate_on_next;
      inv_next = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      cnt_reg <= `CNT_ZERO;
      low_cnt_reg <= `CNT_ZERO;
      gate_on_reg <= 1'b0;
      clr_n_reg <= 1'b1;
      seen_reg <= 1'b0;
      short_reg <= 1'b0;
      nin_reg <= 1'b0;
      inv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      low_cnt_reg <= low_cnt_next;
      gate_on_reg <= gate_on_next;
      clr_n_reg <= clr_n_next;
      seen_reg <= seen_next;
      short_reg <= short_next;
      nin_reg <= nin_next;
      inv_reg <= inv_next;
    end
  end

  assign o_cmd_noninverting_in = nin_reg;
  assign o_cmd_inverting_in = inv_reg;
  assign o_latch_clear_n = clr_n_reg;
  assign o_fault_seen = seen_reg;
  assign o_fault_state = (state_reg != ST_RUN);
  assign o_fault_pulse_short = short_reg;
endmodule

// File: gdrv_chk_assertions.sv
// concurrent checks on the controller ports
`timescale 1ns/1ps
module gdrv_chk (
  input wire logic i_ref_clk, i_rst_n, i_pwm, i_invert_mode, i_auto_reset,
  input wire logic i_fault_n, o_cmd_noninverting_in, o_cmd_inverting_in,
  input wire logic o_latch_clear_n, o_fault_seen, o_fault_state
);
  wire nv = o_cmd_noninverting_in;
  wire man = !i_invert_mode && !i_auto_reset;
  logic [9:0] low_reg;
  logic [2:0] up_reg;
  wire live = up_reg == 3'h5;
  // edges since reset release, and length of clear pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n) {up_reg, low_reg} <= 13'h0000;
    else begin
      up_reg <= live ? up_reg : up_reg + 3'h1;
      low_reg <= o_latch_clear_n ? 10'h000 : low_reg + 10'h001;
    end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence off_s; o_fault_state && !nv && o_fault_seen; endsequence
  sequence clr_s; $fell(o_latch_clear_n); endsequence
  chk_run_follow: assert property (
    live && man && !o_fault_state && !$past(o_fault_state) |-> nv == $past(i_pwm))
    else $error("command lags request");
  chk_inv_quiet: assert property (live && !i_invert_mode |-> !o_cmd_inverting_in)
    else $error("inverting pin not low");
  chk_inv_follow: assert property (
    live && i_invert_mode && !i_auto_reset && !o_fault_state && !$past(o_fault_state) |->
    o_cmd_inverting_in == !$past(i_pwm)) else $error("inverting pin wrong");
  chk_fault_off: assert property (man && $fell(i_fault_n) |-> ##[1:3] off_s)
    else $error("fault not taken");
  chk_latch_hold: assert property (man && o_fault_state |-> !nv)
    else $error("gate on in fault");
  chk_clr_safe: assert property (man ##0 clr_s |-> !nv && !$past(nv))
    else $error("clear while command on");
  chk_clr_len: assert property (man && $rose(o_latch_clear_n) |-> low_reg == 10'h177)
    else $error("clear pulse length");
  chk_auto_clr: assert property (
    live && i_auto_reset && !i_invert_mode |-> o_latch_clear_n == nv)
    else $error("clear not tracking command");
endmodule

// File: gdrv_defs.svh
// timing and configuration constants for the gate driver controller
`ifndef GDRV_DEFS_SVH
`define GDRV_DEFS_SVH
`define CLK_PERIOD_NS 8
`define FAULT_PULSE_MIN_NS 3000
`define FAULT_PULSE_CYC ((`FAULT_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLR_PULSE_CYC_W 10
`define CLR_PULSE_CYC 10'h177
`define CNT_ZERO 10'h000
`define CNT_ONE 10'h001
`define NUM_DRIVERS 6
`endif

// File: gdrv_dev_model.sv
// behavioural gate driver input side with fault latch
`timescale 1ns/1ps
`include "gdrv_defs.svh"
module gdrv_dev_model (
  input wire logic i_vin_p,
  input wire logic i_vin_n,
  input wire logic i_clr_n,
  // sense high means desaturation above the trip level
  input wire logic i_sense,
  input wire logic i_supply_lockout,
  output logic o_gate,
  output wire o_fault_n
);
  logic lat_reg = 1'b0;
  logic hold_reg = 1'b0;
  // set only while on, low clear releases
  always @* if (!i_clr_n) lat_reg = 1'b0; else if (i_sense && o_gate) lat_reg = 1'b1;
  // fault line stays low for the minimum pulse after each trip
  always @(posedge lat_reg) begin
    hold_reg = 1'b1;
    #(`FAULT_PULSE_MIN_NS + 1) hold_reg = 1'b0;
  end
  // gate on only for on command, never in lockout
  assign o_gate = i_vin_p && !i_vin_n && !lat_reg && !i_supply_lockout;
  assign o_fault_n = (lat_reg || hold_reg) ? 1'b0 : 1'bz;
endmodule

// File: gdrv_pkg.sv
// types for the gate driver controller
package gdrv_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_FAULT = 4'h2,
    ST_SAFE = 4'h4,
    ST_CLEAR = 4'h8
  } ctl_state_t;
endpackage

// File: sync2.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  logic q_reg;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= i_d;
      q_reg <= meta_reg;
    end
  end
  assign o_q = q_reg;
endmodule

// File: tb.sv
// self-checking bench for the gate driver controller
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, pwm = 1'b0, inv = 1'b0, auto = 1'b0, ack = 1'b0, sense = 1'b0;
  logic lock = 1'b0;
  tri1 flt;
  wire nv, iv, clr, seen, st, shrt, gate;
  int bad_count = 0, tests_run = 0, cyc = 0;
  // inv, pwm, expected noninverting and inverting pins
  logic [3:0] rows [4] = '{4'h0, 4'h6, 4'hB, 4'hE};
  gate_driver_fault_latch gate_driver_fault_latch_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_pwm(pwm), .i_invert_mode(inv), .i_auto_reset(auto), .i_fault_ack(ack), .i_fault_n(flt),
    .o_cmd_noninverting_in(nv), .o_cmd_inverting_in(iv), .o_latch_clear_n(clr),
    .o_fault_seen(seen), .o_fault_state(st), .o_fault_pulse_short(shrt));
  gdrv_dev_model gdrv_dev_model_inst (.i_vin_p(nv), .i_vin_n(iv), .i_clr_n(clr),
    .i_sense(sense), .i_supply_lockout(lock), .o_gate(gate), .o_fault_n(flt));
  initial forever #4 clk = ~clk;
  task automatic chk(string nm, logic [1:0] got, logic [1:0] exp);
    #1;
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
    @(posedge clk);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 6000) begin
    bad_count++;
    test_done;
  end
  initial begin
    tick(5);
    chk("reset", {clr, nv}, 2'b10);
    rst_n <= 1'b1;
    tick(4);
    foreach (rows[r]) begin
      {inv, pwm} <= rows[r][3:2];
      tick(3);
      chk("pins", {nv, iv}, rows[r][1:0]);
      chk("gate", {gate, 1'b0}, {pwm, 1'b0});
      $display("row %0d done", r);
    end
    for (int m = 0; m < 2; m++) begin
      inv <= m[0];
      pwm <= 1'b1;
      tick(3);
      sense <= 1'b1;
      tick(1);
      sense <= 1'b0;
      tick(380);
      chk("trip", {seen, st}, 2'b11);
      chk("held", {gate, nv}, 2'b00);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      for (int k = 0; k < 9 && clr; k++) tick(1);
      chk("safe", {clr, gate}, 2'b00);
      tick(1);
      chk("release", {flt, 1'b0}, 2'b10);
      for (int k = 0; k < 400 && st; k++) tick(1);
      tick(2);
      chk("resume", {gate, st}, 2'b10);
      $display("fault test %0d done", m);
    end
    inv <= 1'b0;
    auto <= 1'b1;
    pwm <= 1'b0;
    tick(3);
    chk("auto", {clr, nv}, 2'b00);
    pwm <= 1'b1;
    tick(3);
    chk("on", {gate, clr}, 2'b11);
    sense <= 1'b1;
    tick(1);
    sense <= 1'b0;
    tick(10);
    chk("latched", {gate, flt}, 2'b00);
    tick(400);
    pwm <= 1'b0;
    tick(3);
    pwm <= 1'b1;
    tick(3);
    chk("cycle", {gate, flt}, 2'b11);
    chk("width", {shrt, 1'b0}, 2'b00);
    lock <= 1'b1;
    tick(1);
    chk("lockout", {gate, nv}, 2'b01);
    lock <= 1'b0;
    $display("auto test done");
    test_done;
  end
endmodule
bind gate_driver_fault_latch gdrv_chk gdrv_chk_inst (.*);
